/* File: rtl/ceeu_top.sv */
// Exception sequencing: interrupt sync, abort tracking, priority, vectors and reset entry
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ceeu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic normal_irq_request_n,
    input wire logic fast_irq_request_n,
    input wire logic irq_sync_select,
    input wire logic mem_abort,
    input wire ceeu_pkg::ceeu_core_t core_i,
    output ceeu_pkg::ceeu_entry_t entry_o,
    output logic reg_write_block,
    output logic swap_cancel
);
    import ceeu_pkg::*;

    typedef enum logic [1:0] {
        CEEU_ST_RESET,
        CEEU_ST_RUN,
        CEEU_ST_ENTER
    } ceeu_state_t;

    // Interrupt synchronisers: direct sample path and two-flop path, kept apart
    logic fiq_dir_q, fiq_a1_q, fiq_a2_q, irq_dir_q, irq_a1_q, irq_a2_q;
    logic fiq_lvl, irq_lvl, fiq_req, irq_req;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fiq_dir_q <= 1'b1;
            fiq_a1_q <= 1'b1;
            fiq_a2_q <= 1'b1;
            irq_dir_q <= 1'b1;
            irq_a1_q <= 1'b1;
            irq_a2_q <= 1'b1;
        end
        else
        begin
            fiq_dir_q <= fast_irq_request_n;
            fiq_a1_q <= fast_irq_request_n;
            fiq_a2_q <= fiq_a1_q;
            irq_dir_q <= normal_irq_request_n;
            irq_a1_q <= normal_irq_request_n;
            irq_a2_q <= irq_a1_q;
        end
    end

    // State registers
    ceeu_state_t st_q, st_d;
    logic [31:0] sw_q, sw_d;
    logic [31:0] saved_q, saved_d;
    logic [31:0] link_q, link_d;
    logic [31:0] fetch_q, fetch_d;
    logic [31:0] vec_q, vec_d;
    ceeu_kind_t kind_q, kind_d;
    logic [1:0] cnt_q, cnt_d;
    logic take_q, take_d;
    logic pabt_q, pabt_d;
    logic dabt_q, dabt_d;
    logic chain_q, chain_d;
    logic blk_q, blk_d;
    logic swc_q, swc_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;

    // Synchronous-mode select chooses the one-flop path for the shortest delay
    assign fiq_lvl = irq_sync_select ? fiq_dir_q : fiq_a2_q;
    assign irq_lvl = irq_sync_select ? irq_dir_q : irq_a2_q;
    assign fiq_req = !fiq_lvl && !sw_q[CEEU_SW_F_BIT];
    assign irq_req = !irq_lvl && !sw_q[CEEU_SW_I_BIT];

    function automatic logic [31:0] vec_of(input ceeu_kind_t k);
        unique case (k)
            CEEU_K_RESET: vec_of = CEEU_VEC_RESET;
            CEEU_K_UNDEF: vec_of = CEEU_VEC_UNDEF;
            CEEU_K_TRAP: vec_of = CEEU_VEC_TRAP;
            CEEU_K_PABT: vec_of = CEEU_VEC_PABT;
            CEEU_K_DABT: vec_of = CEEU_VEC_DABT;
            CEEU_K_IRQ: vec_of = CEEU_VEC_IRQ;
            CEEU_K_FIQ: vec_of = CEEU_VEC_FIQ;
            default: vec_of = CEEU_VEC_RESET;
        endcase
    endfunction

    function automatic logic [4:0] mode_of(input ceeu_kind_t k);
        unique case (k)
            CEEU_K_UNDEF: mode_of = CEEU_MODE_UND;
            CEEU_K_PABT, CEEU_K_DABT: mode_of = CEEU_MODE_ABT;
            CEEU_K_IRQ: mode_of = CEEU_MODE_IRQ;
            CEEU_K_FIQ: mode_of = CEEU_MODE_FIQ;
            default: mode_of = CEEU_MODE_SVC;
        endcase
    endfunction

    // Offset from the affected instruction so each documented return lands right
    function automatic logic [31:0] link_of(input ceeu_kind_t k, input logic narrow, input logic [31:0] pc);
        logic [31:0] off;
        off = CEEU_LINK_PLUS4;
        unique case (k)
            CEEU_K_DABT: off = CEEU_LINK_PLUS8;
            CEEU_K_UNDEF, CEEU_K_TRAP: off = narrow ? CEEU_LINK_PLUS2 : CEEU_LINK_PLUS4;
            default: off = CEEU_LINK_PLUS4;
        endcase
        link_of = pc + off;
    endfunction

    // Entry status: forced mode, I always set, F on fast entry, T cleared
    function automatic logic [31:0] entry_sw(input ceeu_kind_t k, input logic [31:0] sw);
        logic [31:0] r;
        r = sw;
        r[CEEU_SW_MODE_LSB +: 5] = mode_of(k);
        r[CEEU_SW_I_BIT] = 1'b1;
        if (k == CEEU_K_FIQ)
        begin
            r[CEEU_SW_F_BIT] = 1'b1;
        end
        r[CEEU_SW_T_BIT] = 1'b0;
        entry_sw = r;
    endfunction

    // Exception selection and entry sequencing
    logic dabt_set, pabt_set, pick;
    ceeu_kind_t pick_kind;
    logic sw_wr, ret_wr, acc, mapped;

    assign acc = psel && penable && !pready_q;
    assign mapped = (paddr == CEEU_OFF_STATUS) || (paddr == CEEU_OFF_SAVED) || (paddr == CEEU_OFF_LINK)
        || (paddr == CEEU_OFF_CAUSE) || (paddr == CEEU_OFF_RETURN);
    assign sw_wr = acc && pwrite && (paddr == CEEU_OFF_STATUS) && (sw_q[4:0] != CEEU_MODE_USER);
    assign ret_wr = acc && pwrite && (paddr == CEEU_OFF_RETURN);
    assign dabt_set = core_i.data_cycle && mem_abort;
    assign pabt_set = core_i.fetch_cycle && mem_abort;

    always_comb
    begin
        pick = 1'b1;
        pick_kind = CEEU_K_DABT;
        if (dabt_q)
        begin
            pick_kind = CEEU_K_DABT;
        end
        else if (fiq_req)
        begin
            pick_kind = CEEU_K_FIQ;
        end
        else if (irq_req)
        begin
            pick_kind = CEEU_K_IRQ;
        end
        else if (pabt_q)
        begin
            pick_kind = CEEU_K_PABT;
        end
        else if (core_i.undef_decode)
        begin
            pick_kind = CEEU_K_UNDEF;
        end
        else if (core_i.trap_decode)
        begin
            pick_kind = CEEU_K_TRAP;
        end
        else
        begin
            pick = 1'b0;
        end
    end

    always_comb
    begin
        st_d = st_q;
        sw_d = sw_q;
        saved_d = saved_q;
        link_d = link_q;
        fetch_d = fetch_q;
        vec_d = vec_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        take_d = 1'b0;
        chain_d = chain_q;
        pabt_d = pabt_q;
        dabt_d = dabt_q;
        blk_d = blk_q;
        swc_d = 1'b0;
        if (sw_wr)
        begin
            // A status write may never flip the state bit; a return write restores it from the saved word
            sw_d = {pwdata[31:6], sw_q[CEEU_SW_T_BIT], pwdata[4:0]};
        end
        if (ret_wr)
        begin
            sw_d = saved_q;
        end
        // Tag clears on flush; a set in the same cycle wins
        pabt_d = pabt_q && !core_i.instr_flush;
        blk_d = blk_q && !core_i.instr_end;
        unique case (st_q)
            CEEU_ST_RESET:
            begin
                fetch_d = fetch_q + CEEU_FETCH_STEP;
                if (core_i.reset_n)
                begin
                    link_d = core_i.pc;
                    saved_d = sw_q;
                    sw_d = CEEU_SW_RESET;
                    fetch_d = CEEU_VEC_RESET;
                    vec_d = CEEU_VEC_RESET;
                    kind_d = CEEU_K_RESET;
                    take_d = 1'b1;
                    st_d = CEEU_ST_RUN;
                end
            end
            CEEU_ST_RUN:
            begin
                if (core_i.instr_end && pick && !sw_wr && !ret_wr)
                begin
                    kind_d = pick_kind;
                    link_d = link_of(pick_kind, sw_q[CEEU_SW_T_BIT], core_i.pc);
                    saved_d = sw_q;
                    cnt_d = (pick_kind == CEEU_K_DABT) ? CEEU_CNT_EXC : CEEU_CNT_ENTRY;
                    chain_d = (pick_kind == CEEU_K_DABT) && fiq_req;
                    dabt_d = dabt_q && (pick_kind != CEEU_K_DABT);
                    pabt_d = pabt_d && (pick_kind != CEEU_K_PABT);
                    st_d = CEEU_ST_ENTER;
                end
            end
            CEEU_ST_ENTER:
            begin
                cnt_d = cnt_q - 2'h1;
                if (chain_q && take_q)
                begin
                    // Abort entry has stood a cycle; fast entry follows, its link resuming the abort handler
                    chain_d = 1'b0;
                    kind_d = CEEU_K_FIQ;
                    link_d = vec_q + CEEU_LINK_PLUS4;
                    saved_d = sw_q;
                end
                if (cnt_q == 2'h1)
                begin
                    sw_d = entry_sw(kind_q, saved_q);
                    vec_d = vec_of(kind_q);
                    fetch_d = vec_of(kind_q);
                    take_d = 1'b1;
                    cnt_d = chain_q ? CEEU_CNT_ENTRY : 2'h0;
                    st_d = chain_q ? CEEU_ST_ENTER : CEEU_ST_RUN;
                end
            end
            default:
            begin
                st_d = CEEU_ST_RESET;
            end
        endcase
        if (dabt_set)
        begin
            dabt_d = 1'b1;
            blk_d = blk_d || core_i.block_exec;
            swc_d = core_i.swap_exec;
        end
        if (pabt_set)
        begin
            pabt_d = 1'b1;
        end
        if (!core_i.reset_n)
        begin
            // Core reset abandons whatever was in progress
            st_d = CEEU_ST_RESET;
            take_d = 1'b0;
            pabt_d = 1'b0;
            dabt_d = 1'b0;
            chain_d = 1'b0;
            blk_d = 1'b0;
            swc_d = 1'b0;
            if (st_q != CEEU_ST_RESET)
            begin
                fetch_d = fetch_q + CEEU_FETCH_STEP;
            end
        end
    end

    // Register bus: one wait state, error on unmapped offsets
    always_comb
    begin
        pready_d = acc;
        pslverr_d = acc && !mapped;
        prdata_d = 32'h0000_0000;
        if (acc && !pwrite)
        begin
            unique case (paddr)
                CEEU_OFF_STATUS: prdata_d = sw_q;
                CEEU_OFF_SAVED: prdata_d = saved_q;
                CEEU_OFF_LINK: prdata_d = link_q;
                CEEU_OFF_CAUSE: prdata_d = {22'h00_0000, blk_q, chain_q, dabt_q, pabt_q,
                    !fiq_lvl, !irq_lvl, 1'b0, kind_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= CEEU_ST_RESET;
            sw_q <= CEEU_SW_RESET;
            saved_q <= 32'h0000_0000;
            link_q <= 32'h0000_0000;
            fetch_q <= CEEU_VEC_RESET;
            vec_q <= CEEU_VEC_RESET;
            kind_q <= CEEU_K_RESET;
            cnt_q <= 2'h0;
            take_q <= 1'b0;
            chain_q <= 1'b0;
            pabt_q <= 1'b0;
            dabt_q <= 1'b0;
            blk_q <= 1'b0;
            swc_q <= 1'b0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            st_q <= st_d;
            sw_q <= sw_d;
            saved_q <= saved_d;
            link_q <= link_d;
            fetch_q <= fetch_d;
            vec_q <= vec_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            take_q <= take_d;
            chain_q <= chain_d;
            pabt_q <= pabt_d;
            dabt_q <= dabt_d;
            blk_q <= blk_d;
            swc_q <= swc_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign reg_write_block = blk_q;
    assign swap_cancel = swc_q;
    assign entry_o.take = take_q;
    assign entry_o.kind = kind_q;
    assign entry_o.vector = vec_q;
    assign entry_o.link = link_q;
    assign entry_o.saved = saved_q;
    assign entry_o.status = sw_q;
    assign entry_o.fetch_addr = fetch_q;

endmodule

`default_nettype wire

/* File: inc/ceeu_pkg.sv */
// Constants, types and register map of the exception entry unit
package ceeu_pkg;

    // Register byte offsets
    localparam logic [7:0] CEEU_OFF_STATUS = 8'h00;
    localparam logic [7:0] CEEU_OFF_SAVED = 8'h04;
    localparam logic [7:0] CEEU_OFF_LINK = 8'h08;
    localparam logic [7:0] CEEU_OFF_CAUSE = 8'h0c;
    localparam logic [7:0] CEEU_OFF_RETURN = 8'h10;

    // Status word field positions
    localparam int CEEU_SW_MODE_LSB = 0;
    localparam int CEEU_SW_T_BIT = 5;
    localparam int CEEU_SW_F_BIT = 6;
    localparam int CEEU_SW_I_BIT = 7;

    // Mode field codes
    localparam logic [4:0] CEEU_MODE_USER = 5'h10;
    localparam logic [4:0] CEEU_MODE_FIQ = 5'h11;
    localparam logic [4:0] CEEU_MODE_IRQ = 5'h12;
    localparam logic [4:0] CEEU_MODE_SVC = 5'h13;
    localparam logic [4:0] CEEU_MODE_ABT = 5'h17;
    localparam logic [4:0] CEEU_MODE_UND = 5'h1b;

    // Vector addresses
    localparam logic [31:0] CEEU_VEC_RESET = 32'h0000_0000;
    localparam logic [31:0] CEEU_VEC_UNDEF = 32'h0000_0004;
    localparam logic [31:0] CEEU_VEC_TRAP = 32'h0000_0008;
    localparam logic [31:0] CEEU_VEC_PABT = 32'h0000_000c;
    localparam logic [31:0] CEEU_VEC_DABT = 32'h0000_0010;
    localparam logic [31:0] CEEU_VEC_IRQ = 32'h0000_0018;
    localparam logic [31:0] CEEU_VEC_FIQ = 32'h0000_001c;

    // Link offsets added to the address of the affected instruction
    localparam logic [31:0] CEEU_LINK_PLUS2 = 32'h0000_0002;
    localparam logic [31:0] CEEU_LINK_PLUS4 = 32'h0000_0004;
    localparam logic [31:0] CEEU_LINK_PLUS8 = 32'h0000_0008;
    localparam logic [31:0] CEEU_FETCH_STEP = 32'h0000_0004;

    // Status word after reset release: supervisor, both disables set, 32-bit state
    localparam logic [31:0] CEEU_SW_RESET = 32'h0000_00d3;

    // Entry timing in processor cycles
    localparam int CEEU_T_SYNC_MAX = 3;
    localparam int CEEU_T_BLOCK_LOAD = 20;
    localparam int CEEU_T_EXC = 3;
    localparam int CEEU_T_FIQ = 2;
    localparam int CEEU_T_MIN_LATENCY = 4;
    localparam logic [1:0] CEEU_CNT_EXC = 2'(CEEU_T_EXC);
    localparam logic [1:0] CEEU_CNT_ENTRY = 2'(CEEU_T_FIQ);

    typedef enum logic [2:0] {
        CEEU_K_RESET,
        CEEU_K_UNDEF,
        CEEU_K_TRAP,
        CEEU_K_PABT,
        CEEU_K_DABT,
        CEEU_K_IRQ,
        CEEU_K_FIQ
    } ceeu_kind_t;

    // Pipeline view offered by the core
    typedef struct packed {
        logic reset_n;
        logic instr_end;
        logic instr_flush;
        logic fetch_cycle;
        logic data_cycle;
        logic undef_decode;
        logic trap_decode;
        logic swap_exec;
        logic block_exec;
        logic [31:0] pc;
    } ceeu_core_t;

    // Exception entry handed back to the core
    typedef struct packed {
        logic take;
        ceeu_kind_t kind;
        logic [31:0] vector;
        logic [31:0] link;
        logic [31:0] saved;
        logic [31:0] status;
        logic [31:0] fetch_addr;
    } ceeu_entry_t;

endpackage

/* File: test/ceeu_properties.sv */
// Concurrent checks on the exception entry unit ports
`timescale 1ns/100ps
`default_nettype none
module ceeu_properties
    import ceeu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic mem_abort,
    input wire ceeu_pkg::ceeu_core_t core_i,
    input wire ceeu_pkg::ceeu_entry_t entry_o,
    input wire logic reg_write_block,
    input wire logic swap_cancel
);
    logic tk;
    logic [4:0] md;
    assign tk = entry_o.take;
    assign md = entry_o.status[4:0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_bus_answer;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late or long");
    property p_fiq_entry;
        tk && entry_o.kind == CEEU_K_FIQ |-> entry_o.vector == CEEU_VEC_FIQ && md == CEEU_MODE_FIQ
            && entry_o.status[CEEU_SW_I_BIT] && entry_o.status[CEEU_SW_F_BIT];
    endproperty
    a_fiq_entry: assert property (p_fiq_entry) else $error("fast entry wrong");
    property p_irq_entry;
        tk && entry_o.kind == CEEU_K_IRQ |-> entry_o.vector == CEEU_VEC_IRQ && md == CEEU_MODE_IRQ
            && entry_o.status[CEEU_SW_I_BIT];
    endproperty
    a_irq_entry: assert property (p_irq_entry) else $error("normal entry wrong");
    property p_irq_unmasked;
        tk && entry_o.kind == CEEU_K_IRQ |-> !entry_o.saved[CEEU_SW_I_BIT];
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked) else $error("normal entry while disabled");
    property p_abort_entry;
        tk && (entry_o.kind == CEEU_K_DABT || entry_o.kind == CEEU_K_PABT) |-> md == CEEU_MODE_ABT
            && entry_o.vector == (entry_o.kind == CEEU_K_DABT ? CEEU_VEC_DABT : CEEU_VEC_PABT);
    endproperty
    a_abort_entry: assert property (p_abort_entry) else $error("abort entry wrong");
    property p_trap_entry;
        tk && entry_o.kind == CEEU_K_TRAP |-> entry_o.vector == CEEU_VEC_TRAP && md == CEEU_MODE_SVC;
    endproperty
    a_trap_entry: assert property (p_trap_entry) else $error("trap entry wrong");
    property p_undef_entry;
        tk && entry_o.kind == CEEU_K_UNDEF |-> entry_o.vector == CEEU_VEC_UNDEF && md == CEEU_MODE_UND;
    endproperty
    a_undef_entry: assert property (p_undef_entry) else $error("undefined entry wrong");
    property p_wide_state;
        tk |-> !entry_o.status[CEEU_SW_T_BIT];
    endproperty
    a_wide_state: assert property (p_wide_state) else $error("entry left in short state");
    property p_reset_release;
        !core_i.reset_n ##1 core_i.reset_n |=> entry_o.status == CEEU_SW_RESET && entry_o.fetch_addr == 32'h0;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("reset release state wrong");
    property p_reset_fetch;
        presetn && !core_i.reset_n |=> entry_o.fetch_addr == $past(entry_o.fetch_addr) + CEEU_FETCH_STEP;
    endproperty
    a_reset_fetch: assert property (p_reset_fetch) else $error("fetch not stepping in reset");
    property p_swap_cancel;
        core_i.data_cycle && mem_abort && core_i.swap_exec |=> swap_cancel;
    endproperty
    a_swap_cancel: assert property (p_swap_cancel) else $error("swap not cancelled");
    property p_block_hold;
        reg_write_block && !core_i.instr_end |=> reg_write_block;
    endproperty
    a_block_hold: assert property (p_block_hold) else $error("write block dropped early");
    property p_block_set;
        core_i.data_cycle && mem_abort && core_i.block_exec && core_i.reset_n |=> reg_write_block;
    endproperty
    a_block_set: assert property (p_block_set) else $error("write block not raised");
endmodule

bind ceeu_top ceeu_properties ceeu_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .mem_abort(mem_abort), .core_i(core_i), .entry_o(entry_o),
    .reg_write_block(reg_write_block), .swap_cancel(swap_cancel));
`default_nettype wire

/* File: test/ceeu_far_end.sv */
// Interrupt sources and memory abort signalling beside the unit
`timescale 1ns/100ps
`default_nettype none
module ceeu_far_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_want,
    input wire logic fiq_want,
    input wire logic abort_want,
    input wire logic mem_cycle,
    output logic normal_irq_request_n,
    output logic fast_irq_request_n,
    output logic mem_abort
);
    // Abort only means something inside a memory cycle, so it idles low elsewhere
    assign mem_abort = abort_want && mem_cycle;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            normal_irq_request_n <= 1'b1;
            fast_irq_request_n <= 1'b1;
        end
        else
        begin
            normal_irq_request_n <= !irq_want;
            fast_irq_request_n <= !fiq_want;
        end
    end
endmodule
`default_nettype wire

/* File: test/ceeu_top_test.sv */
// Self-checking bench for the exception entry unit
`timescale 1ns/100ps
`default_nettype none
module ceeu_top_test;
    import ceeu_pkg::*;
    typedef struct {
        logic bus;
        logic chk;
        logic [31:0] v;
        logic [31:0] w;
        logic [4:0] m;
        ceeu_kind_t k;
    } ceeu_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_sync_select, mem_abort;
    logic normal_irq_request_n, fast_irq_request_n, reg_write_block, swap_cancel;
    logic irq_want, fiq_want, abort_want;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    ceeu_core_t core;
    ceeu_entry_t entry;
    ceeu_note_t notes[$];
    ceeu_note_t n;
    int miscompares = 0;
    int checks_done = 0;
    ceeu_kind_t kind_tab[7] = '{CEEU_K_FIQ, CEEU_K_IRQ, CEEU_K_DABT, CEEU_K_PABT, CEEU_K_UNDEF, CEEU_K_TRAP,
        CEEU_K_DABT};
    logic [31:0] vec_tab[7] = '{CEEU_VEC_FIQ, CEEU_VEC_IRQ, CEEU_VEC_DABT, CEEU_VEC_PABT, CEEU_VEC_UNDEF,
        CEEU_VEC_TRAP, CEEU_VEC_DABT};
    logic [4:0] mode_tab[7] = '{CEEU_MODE_FIQ, CEEU_MODE_IRQ, CEEU_MODE_ABT, CEEU_MODE_ABT, CEEU_MODE_UND,
        CEEU_MODE_SVC, CEEU_MODE_ABT};
    logic [31:0] off_tab[7] = '{CEEU_LINK_PLUS4, CEEU_LINK_PLUS4, CEEU_LINK_PLUS8, CEEU_LINK_PLUS4,
        CEEU_LINK_PLUS4, CEEU_LINK_PLUS4, CEEU_LINK_PLUS8};

    ceeu_top ceeu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .normal_irq_request_n(normal_irq_request_n), .fast_irq_request_n(fast_irq_request_n),
        .irq_sync_select(irq_sync_select), .mem_abort(mem_abort), .core_i(core), .entry_o(entry),
        .reg_write_block(reg_write_block), .swap_cancel(swap_cancel));
    ceeu_far_end ceeu_far_end_inst (.pclk(pclk), .presetn(presetn), .irq_want(irq_want), .fiq_want(fiq_want),
        .abort_want(abort_want), .mem_cycle(core.fetch_cycle || core.data_cycle),
        .normal_irq_request_n(normal_irq_request_n), .fast_irq_request_n(fast_irq_request_n),
        .mem_abort(mem_abort));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Results arrive strictly in request order, so one queue serves bus and entries
    always @(posedge pclk)
    begin
        if (presetn && (pready || entry.take))
        begin
            checks_done++;
            if (notes.size() == 0)
            begin
                miscompares++;
                $display("wrong value at %0t: result with nothing expected", $time);
            end
            else
            begin
                n = notes.pop_front();
                if (n.bus && (pslverr !== n.w[0] || (n.chk && prdata !== n.v)))
                    $display("wrong value at %0t: bus answer", $time);
                if (!n.bus && (entry.kind !== n.k || entry.vector !== n.v || entry.status[4:0] !== n.m))
                    $display("wrong value at %0t: entry kind, vector or mode", $time);
                if (!n.bus && n.chk && entry.link !== n.w)
                    $display("wrong value at %0t: entry link", $time);
                if ((n.bus && (pslverr !== n.w[0] || (n.chk && prdata !== n.v))) || (!n.bus && (entry.kind !== n.k
                    || entry.vector !== n.v || entry.status[4:0] !== n.m || (n.chk && entry.link !== n.w))))
                    miscompares++;
            end
        end
    end

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        notes.push_back('{1'b1, !wr && !err, d, {31'h0, err}, 5'h0, CEEU_K_RESET});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic unmask;
        bus(1'b1, CEEU_OFF_STATUS, 32'(CEEU_MODE_SVC), 1'b0);
    endtask

    function automatic void expect_entry(ceeu_kind_t k, logic [31:0] v, logic [4:0] m, logic [31:0] l, logic c);
        notes.push_back('{1'b0, c, v, l, m, k});
    endfunction

    task automatic end_instr;
        @(posedge pclk);
        core.instr_end <= 1'b1;
        @(posedge pclk);
        core.instr_end <= 1'b0;
        core.undef_decode <= 1'b0;
        core.trap_decode <= 1'b0;
        core.block_exec <= 1'b0;
        repeat (8) @(posedge pclk);
        checks_done++;
        if (notes.size() != 0)
        begin
            miscompares++;
            $display("wrong value at %0t: entry missing", $time);
            notes.delete();
        end
    endtask

    // Source index: 0 fast, 1 normal, 2 swap abort, 3 fetch abort, 4 undefined, 5 trap, 6 block abort
    task automatic fire(input int i);
        @(posedge pclk);
        core.pc <= $urandom & 32'hffff_fffc;
        case (i)
            0: fiq_want <= 1'b1;
            1: irq_want <= 1'b1;
            4: core.undef_decode <= 1'b1;
            5: core.trap_decode <= 1'b1;
            default:
            begin
                abort_want <= 1'b1;
                core.fetch_cycle <= (i == 3);
                core.data_cycle <= (i != 3);
                core.swap_exec <= (i == 2);
                core.block_exec <= (i == 6);
                @(posedge pclk);
                abort_want <= 1'b0;
                core.fetch_cycle <= 1'b0;
                core.data_cycle <= 1'b0;
                core.swap_exec <= 1'b0;
            end
        endcase
        repeat (4) @(posedge pclk);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        core = '0;
        irq_want = 1'b0;
        fiq_want = 1'b0;
        abort_want = 1'b0;
        void'($urandom(32'h7d8a101c));
        irq_sync_select = 1'($urandom);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        expect_entry(CEEU_K_RESET, CEEU_VEC_RESET, CEEU_MODE_SVC, 32'h0, 1'b0);
        core.reset_n <= 1'b1;
        repeat (6) @(posedge pclk);
        bus(1'b0, CEEU_OFF_STATUS, CEEU_SW_RESET, 1'b0);
        bus(1'b0, 8'h14, 32'h0, 1'b1);
        unmask();
        bus(1'b0, CEEU_OFF_STATUS, 32'(CEEU_MODE_SVC), 1'b0);
        for (int i = 0; i < 7; i++)
        begin
            fire(i);
            expect_entry(kind_tab[i], vec_tab[i], mode_tab[i], core.pc + off_tab[i], 1'b1);
            end_instr();
            fiq_want <= 1'b0;
            irq_want <= 1'b0;
            unmask();
        end
        irq_sync_select <= !irq_sync_select;
        bus(1'b1, CEEU_OFF_STATUS, 32'h0000_0093, 1'b0);
        fire(1);
        end_instr();
        unmask();
        expect_entry(CEEU_K_IRQ, CEEU_VEC_IRQ, CEEU_MODE_IRQ, core.pc + CEEU_LINK_PLUS4, 1'b1);
        end_instr();
        irq_want <= 1'b0;
        bus(1'b1, CEEU_OFF_RETURN, 32'h0, 1'b0);
        bus(1'b0, CEEU_OFF_STATUS, 32'(CEEU_MODE_SVC), 1'b0);
        irq_want <= 1'b1;
        fire(0);
        expect_entry(CEEU_K_FIQ, CEEU_VEC_FIQ, CEEU_MODE_FIQ, core.pc + CEEU_LINK_PLUS4, 1'b1);
        end_instr();
        fiq_want <= 1'b0;
        irq_want <= 1'b0;
        unmask();
        fiq_want <= 1'b1;
        fire(2);
        expect_entry(CEEU_K_DABT, CEEU_VEC_DABT, CEEU_MODE_ABT, core.pc + CEEU_LINK_PLUS8, 1'b1);
        expect_entry(CEEU_K_FIQ, CEEU_VEC_FIQ, CEEU_MODE_FIQ, CEEU_VEC_DABT + CEEU_LINK_PLUS4, 1'b1);
        end_instr();
        fiq_want <= 1'b0;
        unmask();
        fire(3);
        core.instr_flush <= 1'b1;
        @(posedge pclk);
        core.instr_flush <= 1'b0;
        end_instr();
        core.reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        expect_entry(CEEU_K_RESET, CEEU_VEC_RESET, CEEU_MODE_SVC, 32'h0, 1'b0);
        core.reset_n <= 1'b1;
        repeat (6) @(posedge pclk);
        bus(1'b0, CEEU_OFF_STATUS, CEEU_SW_RESET, 1'b0);
        tally_and_finish();
    end

    initial
    begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        $display("wrong value at %0t: run timed out", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
